/* test/agic_global_irq_bench.sv */
// Purpose: register-level test of pending word and coalescing
// Assumes: inputs driven at falling edge
// Notes: timer case runs one real millisecond
`timescale 1ns/1ps
`default_nettype none
module agic_global_irq_bench;
  // ==========
  // signals
  logic clk, resetn, regSel, regWr, availLoadEn, regRvalid, coalesceIrq, anyPending;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, availLoad, portIrqEvent, portCmdComplete, portCmdBusy;
  logic [4:0] maxPortCount, coalesceVector;
  logic [31:0] ld [5] = '{32'h0, 32'h0000_007f, 32'h8000_0001, 32'h0000_0022, 32'h0000_000f};
  logic [31:0] ex [5] = '{32'h0000_000f, 32'h0000_000f, 32'h0000_000f, 32'h0000_0022, 32'h0000_000f};
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  int irqCnt = 0;
  int n, c;
  agic_global_irq dut (.clk(clk), .resetn(resetn), .regSel(regSel), .regWr(regWr), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid), .availLoad(availLoad),
    .availLoadEn(availLoadEn), .maxPortCount(maxPortCount), .portIrqEvent(portIrqEvent),
    .portCmdComplete(portCmdComplete), .portCmdBusy(portCmdBusy), .coalesceIrq(coalesceIrq),
    .coalesceVector(coalesceVector), .anyPending(anyPending));
  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // ==========
  // irq counter and watchdog
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (coalesceIrq === 1'b1) irqCnt <= irqCnt + 1;
    if (cycles == 30000)
    begin
      fails++;
      give_verdict;
    end
  end
  // ==========
  // tasks
  task give_verdict;
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("FAIL %s exp %h got %h", nm, e, g);
      fails++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    regSel = 1;
    regWr = 1;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regSel = 0;
    regWr = 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    regSel = 1;
    regAddr = a;
    @(negedge clk);
    regSel = 0;
    chk("regRvalid", 1, regRvalid);
    chk($sformatf("reg %h", a), e, regRdata);
  endtask
  // one completion pulse, then time for the sync pipeline
  task pulse(input logic [31:0] b);
    @(negedge clk);
    portCmdComplete = b;
    @(negedge clk);
    portCmdComplete = 0;
    repeat (8) @(negedge clk);
  endtask
  // ==========
  // main sequence
  initial
  begin
    {resetn, regSel, regWr, regAddr, regWdata, availLoad, availLoadEn} = 0;
    {portIrqEvent, portCmdComplete, portCmdBusy} = 0;
    maxPortCount = 5'h05;
    repeat (8) @(negedge clk);
    resetn = 1;
    repeat (4) @(negedge clk);
    rd(8'h08, 32'h0000_0000);
    rd(8'h0c, 32'h0000_000f);
    rd(8'h10, 32'h0001_0100);
    rd(8'h14, 32'h0001_01f8);
    rd(8'h18, 32'h0000_0000);
    rd(8'h1c, 32'h0000_0000);
    chk("coalesceVector", 32'h0000_001f, {27'h000_0000, coalesceVector});
    wr(8'h0c, 32'hffff_ffff);
    wr(8'h10, 32'h0000_0000);
    wr(8'h14, 32'h0000_0000);
    rd(8'h0c, 32'h0000_000f);
    rd(8'h10, 32'h0001_0100);
    rd(8'h14, 32'h0000_00f8);
    foreach (ld[i])
    begin
      availLoad = ld[i];
      availLoadEn = 1;
      repeat (4) @(negedge clk);
      availLoadEn = 0;
      rd(8'h0c, ex[i]);
    end
    portIrqEvent = 32'h0000_00ff;
    repeat (5) @(negedge clk);
    portIrqEvent = 0;
    repeat (4) @(negedge clk);
    chk("anyPending", 1, anyPending);
    rd(8'h08, 32'h0000_000f);
    wr(8'h08, 32'h0000_0005);
    rd(8'h08, 32'h0000_000a);
    // one-cycle event timed to meet the clear at the same edge
    portIrqEvent = 32'h0000_0002;
    @(negedge clk);
    portIrqEvent = 0;
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0000_0002);
    portIrqEvent = 0;
    repeat (4) @(negedge clk);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0000_0000);
    chk("anyPending", 0, anyPending);
    // count threshold 2 then 1, port 0 member only
    wr(8'h18, 32'h0000_0001);
    for (int k = 2; k >= 1; k--)
    begin
      wr(8'h14, {16'hffff, k[7:0], 8'h00});
      wr(8'h14, {16'hffff, k[7:0], 8'h01});
      n = irqCnt;
      pulse(32'h0000_0002);
      repeat (k) pulse(32'h0000_0001);
      chk("irqCnt", n + 1, irqCnt);
      rd(8'h08, 32'h8000_0000);
      wr(8'h08, 32'h8000_0000);
      wr(8'h14, {16'hffff, k[7:0], 8'h00});
    end
    wr(8'h14, 32'hffff_0100);
    n = irqCnt;
    repeat (2) pulse(32'h0000_0001);
    chk("irqCnt", n, irqCnt);
    // zero threshold: only the 1 ms timer fires, and only while busy
    wr(8'h14, 32'h0001_0001);
    n = irqCnt;
    repeat (3) pulse(32'h0000_0001);
    chk("irqCnt", n, irqCnt);
    portCmdBusy = 32'h0000_0001;
    for (c = 0; c < 11000 && irqCnt == n; c++) @(negedge clk);
    portCmdBusy = 0;
    chk("irqCnt", n + 1, irqCnt);
    chk("timerEarly", 1, c >= 9500);
    rd(8'h08, 32'h8000_0000);
    give_verdict;
  end
endmodule // agic_global_irq_bench
`default_nettype wire

/* test/agic_global_irq_properties.sv */
// Purpose: port-level checks of the pending word and coalescing engine
// Assumes: sees top module ports only
// Notes: helper regs mirror control and member writes
`timescale 1ns/1ps
`default_nettype none
module agic_global_irq_properties (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic regSel,
  input wire logic regWr,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic [31:0] regRdata,
  input wire logic regRvalid,
  // straps and events
  input wire logic [4:0] maxPortCount,
  input wire logic [31:0] portCmdComplete,
  input wire logic [31:0] portCmdBusy,
  // outputs
  input wire logic coalesceIrq,
  input wire logic [4:0] coalesceVector,
  input wire logic anyPending
);
  // ==========
  // mirrors; accesses before the reset sync settles are ignored
  logic [2:0] rstCnt;
  logic enQ;
  logic [7:0] ccQ;
  logic [31:0] memQ;
  wire logic ready = rstCnt == 3'd7;
  wire logic rd = ready && regSel && !regWr;
  wire logic wr = ready && regSel && regWr;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      rstCnt <= 3'd0;
      enQ <= 1'b0;
      ccQ <= 8'h01;
      memQ <= 32'h0000_0000;
    end
    else
    begin
      if (!ready) rstCnt <= rstCnt + 3'd1;
      if (wr && regAddr == 8'h14) enQ <= regWdata[0];
      if (wr && regAddr == 8'h14) ccQ <= regWdata[15:8];
      if (wr && regAddr == 8'h18) memQ <= regWdata;
    end
  // ==========
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_vector_fixed: assert property (ready |-> coalesceVector == 5'h1f) else $error("vector wrong");
  a_read_pulse: assert property (ready |=> regRvalid == $past(rd)) else $error("read valid wrong");
  a_version_word: assert property (rd && regAddr == 8'h10 |=> regRdata == 32'h0001_0100) else $error("version");
  a_avail_legal: assert property (rd && regAddr == 8'h0c |=> regRdata != 0 && !regRdata[31]
    && $countones(regRdata) <= maxPortCount + 1) else $error("avail mask illegal");
  a_unmapped_zero: assert property (rd && regAddr == 8'h1c |=> regRdata == 0) else $error("unmapped");
  a_irq_pending: assert property (coalesceIrq |=> anyPending) else $error("irq not pending");
  a_irq_enabled: assert property (coalesceIrq |-> enQ || $past(enQ)) else $error("irq while off");
  // two sync flops, edge detect, output flop: the pulse is seen three edges on
  a_count_fires: assert property (enQ && ccQ == 8'h01 && $rose(|(portCmdComplete & memQ))
    |-> ##3 coalesceIrq) else $error("count irq missing");
  a_quiet_idle: assert property ((portCmdComplete == 0 && portCmdBusy == 0) [*6] |-> !coalesceIrq)
    else $error("irq without cause");
  c_count_irq: cover property (enQ && ccQ == 8'h02 ##1 coalesceIrq);
  c_timer_irq: cover property (ccQ == 8'h00 && coalesceIrq);
  c_ctl_read: cover property (rd && regAddr == 8'h14);
endmodule // agic_global_irq_properties
bind agic_global_irq agic_global_irq_properties chk (.clk(clk), .resetn(resetn), .regSel(regSel),
  .regWr(regWr), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
  .maxPortCount(maxPortCount), .portCmdComplete(portCmdComplete), .portCmdBusy(portCmdBusy),
  .coalesceIrq(coalesceIrq), .coalesceVector(coalesceVector), .anyPending(anyPending));
`default_nettype wire

/* verilog/agic_defs.vh */
// Purpose: constants for the global interrupt and coalescing block
// Assumes: 32-bit register port, byte offsets as word addresses
// Notes: definitions only
`ifndef AGIC_DEFS_VH
`define AGIC_DEFS_VH
// ====================================================
// register offsets
`define AGIC_OFF_PENDING 8'h08
`define AGIC_OFF_AVAIL 8'h0c
`define AGIC_OFF_VERSION 8'h10
`define AGIC_OFF_CTRL 8'h14
`define AGIC_OFF_MEMBERS 8'h18
// ====================================================
// reset values and fixed contents
`define AGIC_AVAIL_RST 32'h0000_000f
`define AGIC_VER_MAJOR 16'h0001
`define AGIC_VER_MINOR 16'h0100
`define AGIC_VECTOR_RST 5'h1f
`define AGIC_THRESH_RST 8'h01
`define AGIC_TIMEOUT_RST 16'h0001
`define AGIC_MAXPORT_RST 5'h05
// ====================================================
// control field positions
`define AGIC_CTL_EN 0
`define AGIC_CTL_VEC_LO 3
`define AGIC_CTL_VEC_HI 7
`define AGIC_CTL_CC_LO 8
`define AGIC_CTL_CC_HI 15
`define AGIC_CTL_TV_LO 16
`define AGIC_CTL_TV_HI 31
// ====================================================
// timing: 10 MHz clock, so 10000 cycles make the 1 ms tick
`define AGIC_TICK_CYC 16'h2710
`endif

/* verilog/agic_global_irq.v */
// Purpose: global pending word, port mask, version and completion coalescing
// Assumes: simple synchronous register port, 32-bit words, read data one cycle late
// Notes: available mask and port count are loaded by firmware through strap inputs
`timescale 1ns/1ps
`default_nettype none
`include "agic_defs.vh"
module agic_global_irq (
  // clock and reset
  input wire clk,
  input wire resetn,
  // register port
  input wire regSel,
  input wire regWr,
  input wire [7:0] regAddr,
  input wire [31:0] regWdata,
  output reg [31:0] regRdata,
  output reg regRvalid,
  // firmware-loaded straps
  input wire [31:0] availLoad,
  input wire availLoadEn,
  input wire [4:0] maxPortCount,
  // port events
  input wire [31:0] portIrqEvent,
  input wire [31:0] portCmdComplete,
  input wire [31:0] portCmdBusy,
  // interrupt outputs
  output reg coalesceIrq,
  output reg [4:0] coalesceVector,
  output reg anyPending
);
  // ====================================================
  // reset release
  reg rstMeta_q;
  reg rstn_q;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstMeta_q <= 1'b0;
      rstn_q <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstn_q <= rstMeta_q;
    end
  end

  // ====================================================
  // helpers
  function [5:0] popCount;
    input [31:0] v;
    integer i;
    begin
      popCount = 6'd0;
      for (i = 0; i < 32; i = i + 1)
        popCount = popCount + {5'd0, v[i]};
    end
  endfunction

  function [7:0] countOnes;
    input [31:0] v;
    integer i;
    begin
      countOnes = 8'h00;
      for (i = 0; i < 32; i = i + 1)
        countOnes = countOnes + {7'd0, v[i]};
    end
  endfunction

  // one address compare shared by every writable word
  function wrHit;
    input sel;
    input wr;
    input [7:0] addr;
    input [7:0] off;
    begin
      wrHit = sel && wr && (addr == off);
    end
  endfunction

  // ====================================================
  // pin synchronisers for port events and firmware straps
  reg [31:0] evtMeta_q;
  reg [31:0] evtSync_q;
  reg [31:0] cmpMeta_q;
  reg [31:0] cmpSync_q;
  reg [31:0] busyMeta_q;
  reg [31:0] busySync_q;
  reg [31:0] availMeta_q;
  reg [31:0] availSync_q;
  reg availEnMeta_q;
  reg availEnSync_q;
  reg [4:0] maxMeta_q;
  reg [4:0] maxSync_q;
  always @(posedge clk or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      evtMeta_q <= 32'h0000_0000;
      evtSync_q <= 32'h0000_0000;
      cmpMeta_q <= 32'h0000_0000;
      cmpSync_q <= 32'h0000_0000;
      busyMeta_q <= 32'h0000_0000;
      busySync_q <= 32'h0000_0000;
      availMeta_q <= 32'h0000_0000;
      availSync_q <= 32'h0000_0000;
      availEnMeta_q <= 1'b0;
      availEnSync_q <= 1'b0;
      maxMeta_q <= 5'h00;
      maxSync_q <= 5'h00;
    end
    else
    begin
      evtMeta_q <= portIrqEvent;
      evtSync_q <= evtMeta_q;
      cmpMeta_q <= portCmdComplete;
      cmpSync_q <= cmpMeta_q;
      busyMeta_q <= portCmdBusy;
      busySync_q <= busyMeta_q;
      availMeta_q <= availLoad;
      availSync_q <= availMeta_q;
      availEnMeta_q <= availLoadEn;
      availEnSync_q <= availEnMeta_q;
      maxMeta_q <= maxPortCount;
      maxSync_q <= maxMeta_q;
    end
  end

  // completion inputs are level strobes; count rising edges only
  reg [31:0] cmpPrev_q;
  always @(posedge clk or negedge rstn_q)
  begin
    if (!rstn_q)
      cmpPrev_q <= 32'h0000_0000;
    else
      cmpPrev_q <= cmpSync_q;
  end
  wire [31:0] cmpRise = cmpSync_q & ~cmpPrev_q;

  // ====================================================
  // register state
  reg [31:0] avail_q;
  reg [4:0] maxPorts_q;
  reg [31:0] pending_q;
  reg [31:0] pending_d;
  reg ctlEn_q;
  reg [7:0] threshWr_q;
  reg [15:0] timeoutWr_q;
  reg [7:0] threshAct_q;
  reg [15:0] timeoutAct_q;
  reg [31:0] members_q;
  reg [7:0] tally_q;
  reg [15:0] countdown_q;
  wire [4:0] vecSel = `AGIC_VECTOR_RST;

  wire wrCtl = wrHit(regSel, regWr, regAddr, `AGIC_OFF_CTRL);
  wire wrMembers = wrHit(regSel, regWr, regAddr, `AGIC_OFF_MEMBERS);
  wire wrPending = wrHit(regSel, regWr, regAddr, `AGIC_OFF_PENDING);
  wire enRise = wrCtl && regWdata[`AGIC_CTL_EN] && !ctlEn_q;

  // ====================================================
  // available mask: firmware load, refused if it breaks the limits
  wire availOk = availSync_q != 32'h0000_0000 &&
                 popCount(availSync_q) <= {1'b0, maxPorts_q} + 6'd1 &&
                 !availSync_q[vecSel];
  always @(posedge clk or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      avail_q <= `AGIC_AVAIL_RST;
      maxPorts_q <= `AGIC_MAXPORT_RST;
    end
    else
    begin
      maxPorts_q <= maxSync_q;
      if (availEnSync_q && availOk)
        avail_q <= availSync_q;
    end
  end

  // ====================================================
  // coalescing engine
  wire [31:0] memberAct = members_q & avail_q;
  // a burst of completions saturates rather than wrapping below the threshold
  wire [8:0] tallySum = {1'b0, tally_q} + {1'b0, countOnes(cmpRise & memberAct)};
  wire [7:0] tallyNext = tallySum[8] ? 8'hff : tallySum[7:0];
  // >= rather than ==: several completions may land in one cycle
  wire countHit = threshAct_q != 8'h00 && tallyNext >= threshAct_q;
  wire busy = |(busySync_q & memberAct);
  wire msTick;
  // a zero timeout fires on the first busy tick instead of wrapping
  wire timerHit = busy && msTick && countdown_q <= 16'h0001;
  wire fire = ctlEn_q && (countHit || timerHit);

  agic_ms_tick u_tick (
    .clk(clk),
    .rstn(rstn_q),
    .restart(enRise),
    .tick(msTick)
  );

  always @(posedge clk or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      ctlEn_q <= 1'b0;
      threshWr_q <= `AGIC_THRESH_RST;
      timeoutWr_q <= `AGIC_TIMEOUT_RST;
      threshAct_q <= `AGIC_THRESH_RST;
      timeoutAct_q <= `AGIC_TIMEOUT_RST;
      members_q <= 32'h0000_0000;
      tally_q <= 8'h00;
      countdown_q <= `AGIC_TIMEOUT_RST;
    end
    else
    begin
      if (wrCtl)
      begin
        ctlEn_q <= regWdata[`AGIC_CTL_EN];
        threshWr_q <= regWdata[`AGIC_CTL_CC_HI:`AGIC_CTL_CC_LO];
        timeoutWr_q <= regWdata[`AGIC_CTL_TV_HI:`AGIC_CTL_TV_LO];
      end
      if (wrMembers)
        members_q <= regWdata;
      if (enRise)
      begin
        // latest written values take effect only on the enable edge
        threshAct_q <= regWdata[`AGIC_CTL_CC_HI:`AGIC_CTL_CC_LO];
        timeoutAct_q <= regWdata[`AGIC_CTL_TV_HI:`AGIC_CTL_TV_LO];
        countdown_q <= regWdata[`AGIC_CTL_TV_HI:`AGIC_CTL_TV_LO];
        tally_q <= 8'h00;
      end
      else if (!ctlEn_q)
        tally_q <= 8'h00;
      else if (fire)
      begin
        tally_q <= 8'h00;
        countdown_q <= timeoutAct_q;
      end
      else
      begin
        tally_q <= tallyNext;
        if (busy && msTick)
          countdown_q <= countdown_q - 16'h0001;
      end
    end
  end

  // ====================================================
  // pending word
  always @*
  begin
    pending_d = pending_q;
    if (wrPending)
      pending_d = pending_d & ~regWdata;
    // sets applied after clears so a same-cycle event survives
    pending_d = pending_d | (evtSync_q & avail_q);
    if (fire)
      pending_d[vecSel] = 1'b1;
    // undefined positions held at zero
    pending_d = pending_d & (avail_q | (32'h0000_0001 << vecSel));
  end

  always @(posedge clk or negedge rstn_q)
  begin
    if (!rstn_q)
      pending_q <= 32'h0000_0000;
    else
      pending_q <= pending_d;
  end

  // ====================================================
  // read path and outputs
  reg [31:0] rdMux;
  always @*
  begin
    case (regAddr)
      `AGIC_OFF_PENDING: rdMux = pending_q;
      `AGIC_OFF_AVAIL: rdMux = avail_q;
      `AGIC_OFF_VERSION: rdMux = {`AGIC_VER_MAJOR, `AGIC_VER_MINOR};
      `AGIC_OFF_CTRL: rdMux = {timeoutWr_q, threshWr_q, vecSel, 2'b00, ctlEn_q};
      `AGIC_OFF_MEMBERS: rdMux = members_q;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      regRdata <= 32'h0000_0000;
      regRvalid <= 1'b0;
      coalesceIrq <= 1'b0;
      coalesceVector <= 5'h00;
      anyPending <= 1'b0;
    end
    else
    begin
      regRvalid <= regSel && !regWr;
      regRdata <= (regSel && !regWr) ? rdMux : 32'h0000_0000;
      coalesceIrq <= fire;
      coalesceVector <= vecSel;
      anyPending <= |pending_d;
    end
  end
endmodule // agic_global_irq
`default_nettype wire

/* verilog/agic_ms_tick.v */
// Purpose: one-cycle enable pulse every millisecond
// Assumes: single clock, synchronous reset copy
// Notes: exact division, well inside the 5% accuracy band
`timescale 1ns/1ps
`default_nettype none
`include "agic_defs.vh"
module agic_ms_tick #(
  parameter [15:0] TICK_CYC = `AGIC_TICK_CYC
)(
  // clock and reset
  input wire clk,
  input wire rstn,
  // control
  input wire restart,
  output reg tick
);
  reg [15:0] count_q;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count_q <= 16'h0000;
      tick <= 1'b0;
    end
    else if (restart || count_q == TICK_CYC - 16'h0001)
    begin
      count_q <= 16'h0000;
      tick <= !restart;
    end
    else
    begin
      count_q <= count_q + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule // agic_ms_tick
`default_nettype wire
